// ### src/ovt_pkg.sv
// Shared constants, register map and types for the dual-role support block
package ovt_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

  // State timer timeouts and test intervals, in milliseconds
  localparam int unsigned TA_WAIT_VRISE_MS = 100;
  localparam int unsigned TA_WAIT_BCON_MS = 1000;
  localparam int unsigned TA_AIDL_BDIS_MS = 200;
  localparam int unsigned TB_ASE0_BRST_MS = 4;
  localparam int unsigned TB_SE0_SRP_MS = 2;
  localparam int unsigned TEST_STEP_MS = 15_000;
  localparam int unsigned RESUME_K_MS = 20;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h04;
  localparam logic [7:0] OFS_EVENT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_TEST_ID = 8'h14;
  localparam logic [7:0] OFS_TEST_PORT = 8'h18;
  localparam logic [7:0] OFS_TEST_STAT = 8'h1c;

  // CTRL fields
  localparam int CTRL_SUSP_REQ = 0;
  localparam int CTRL_CHRG_VBUS = 1;
  localparam int CTRL_DRV_VBUS = 2;
  localparam int CTRL_LOC_CONN = 3;
  localparam int CTRL_LOC_SOF = 4;
  localparam int CTRL_BUS_RST = 5;
  localparam int CTRL_W = 6;

  // EVENT fields, self-clearing
  localparam int EV_A_HNP_SENT = 0;
  localparam int EV_B_HNP_ACCEPT = 1;
  localparam int EV_B_BUS_RESET = 2;
  localparam int EV_HC_RESET = 3;
  localparam int EV_FIXTURE_ACK = 4;

  // FLAGS fields, W1C
  localparam int FL_VBUS_OVERCUR = 0;
  localparam int FL_ASE0_RESET = 1;

  // Test port field width
  localparam int PORT_W = 4;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [PORT_W-1:0] PORT_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_OTHER,
    ST_B_IDLE,
    ST_A_WAIT_VRISE,
    ST_A_WAIT_BCON,
    ST_A_SUSPEND,
    ST_B_WAIT_ACON
  } ovt_otg_state_t;

  typedef enum logic [2:0] {
    TM_NONE,
    TM_SE0_NAK,
    TM_J,
    TM_K,
    TM_PACKET,
    TM_SUSP_RES,
    TM_STEP_DESC,
    TM_STEP_DATA
  } ovt_test_mode_t;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_SOF_A,
    PH_SUSP,
    PH_RESUME,
    PH_WAIT_ACK,
    PH_SOF_B,
    PH_DONE
  } ovt_phase_t;

  typedef struct packed {
    logic id;
    logic a_vbus_vld;
    logic a_sess_vld;
    logic b_sess_vld;
    logic b_sess_end;
    logic se0;
  } ovt_sense_t;

  typedef struct packed {
    logic hs_rx;
    logic drive_se0;
    logic drive_j;
    logic drive_k;
    logic send_packet;
    logic suspend;
    logic resume_k;
    logic sof_en;
  } ovt_port_ctl_t;

endpackage

// ### src/ovt_core.sv
// Dual-role input/flag/output logic, state timers and test-mode dispatcher
// Function
// - In B idle, flag SE0 lasting beyond the pre-SRP minimum.
// - Flag session-end below, session-valid above their thresholds.
// - id reads low with an A plug inserted, high otherwise.
// - Suspend-request output holds while software wants the bus suspended.
// - A-side HNP flag sets after feature sent, clears on wait-bcon entry or reset.
// - B-side HNP flag sets on accept, clears on bus reset or lost session.
// - Charge-VBUS and drive-VBUS outputs follow their control bits.
// - Local-connect output shows this device signalling a connection.
// - Local-activity output high while this device makes bus activity.
// - Each state timer starts on state entry and clears on exit.
// - VBUS-rise timeout without VBUS valid flags overcurrent.
// - B-connect wait timeout lets the A side stop waiting.
// - Suspend disconnect timeout lets the A side end the session.
// - B SE0-to-reset timeout in wait-A-connect is treated as bus reset.
// - Compliance test device identity is flagged unsupported.
// - Test modes act on the port where the fixture is attached.
// - A test mode holds until the host controller reset event.
// - SE0-NAK code: high-speed receive and drive SE0 until reset.
// - J, K, packet codes hold J, K or send packets until reset.
// - Suspend-resume: SOFs 15 s, suspend 15 s, then resume K and SOFs.
// - Single-step descriptor: SOFs 15 s then GetDescriptor, SOFs continue.
// - Single-step data: GetDescriptor, fixture ACK, SOFs 15 s, then IN.
`timescale 1ns/1ps
module ovt_core
  import ovt_pkg::*;
#(
  parameter int unsigned VRISE_CYC = TA_WAIT_VRISE_MS * CYC_PER_MS,
  parameter int unsigned BCON_CYC = TA_WAIT_BCON_MS * CYC_PER_MS,
  parameter int unsigned AIDL_CYC = TA_AIDL_BDIS_MS * CYC_PER_MS,
  parameter int unsigned ASE0_CYC = TB_ASE0_BRST_MS * CYC_PER_MS,
  parameter int unsigned SE0_SRP_CYC = TB_SE0_SRP_MS * CYC_PER_MS,
  parameter int unsigned STEP_CYC = TEST_STEP_MS * CYC_PER_MS,
  parameter int unsigned RESUME_CYC = RESUME_K_MS * CYC_PER_MS,
  // Identity values are arbitrary
  parameter logic [15:0] TEST_VID = 16'h5a5a,
  parameter logic [15:0] PID_TEST_DEV = 16'h7700,
  parameter logic [15:0] PID_SE0_NAK = 16'h7701,
  parameter logic [15:0] PID_J = 16'h7702,
  parameter logic [15:0] PID_K = 16'h7703,
  parameter logic [15:0] PID_PACKET = 16'h7704,
  parameter logic [15:0] PID_SUSP_RES = 16'h7706,
  parameter logic [15:0] PID_STEP_DESC = 16'h7707,
  parameter logic [15:0] PID_STEP_DATA = 16'h7708
) (
  input wire logic clock_i, // 10 MHz controller clock
  input wire logic arst_n_i, // Asynchronous reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction, high for write
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error for unmapped address
  input wire ovt_sense_t sense_i, // Comparator and line-state pins
  output logic id_o, // Synchronised id level
  output logic a_suspend_req_o, // Application bus suspend request
  output logic chrg_vbus_o, // Charge VBUS through resistor
  output logic drv_vbus_o, // Drive VBUS
  output logic loc_conn_o, // Local connect signalled
  output logic loc_sof_o, // Local bus activity
  output logic b_se0_srp_o, // SE0 long enough before SRP
  output logic a_set_b_hnp_en_o, // Peer HNP enabled by this A side
  output logic b_hnp_en_o, // Local HNP enabled as B side
  output logic [3:0] tmout_o, // Timeouts: vrise, bcon, aidl_bdis, ase0_brst
  output logic unsupported_o, // Compliance test device identity seen
  output ovt_test_mode_t test_mode_o, // Active test mode
  output logic [PORT_W-1:0] test_port_o, // Port under test
  output ovt_port_ctl_t port_ctl_o, // Port drive for the port under test
  output logic step_setup_o, // Pulse: issue GetDescriptor(Device)
  output logic step_in_o // Pulse: issue IN for descriptor data
);

  // Two-stage pin synchroniser
  ovt_sense_t sense_s1_ff;
  ovt_sense_t sense_ff;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sense_s1_ff <= '0;
      sense_ff <= '0;
    end else begin
      sense_s1_ff <= sense_i;
      sense_ff <= sense_s1_ff;
    end
  end

  // APB slave, one access cycle, no wait states
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic setup;
  logic wr_en;
  logic addr_ok;
  logic [31:0] rd_mux;

  assign setup = psel_i && !penable_i;
  assign wr_en = psel_i && penable_i && pwrite_i && pready_ff && !pslverr_ff;

  function automatic logic wr_to(input logic [7:0] ofs);
    wr_to = wr_en && (paddr_i == ofs);
  endfunction

  // Register state
  logic [CTRL_W-1:0] ctrl_ff;
  ovt_otg_state_t state_ff;
  ovt_otg_state_t prev_state_ff;
  logic [PORT_W-1:0] port_ff;
  logic [31:0] test_id_ff;
  logic [1:0] flags_ff;
  logic a_hnp_ff;
  logic b_hnp_ff;
  logic se0_srp_ff;
  logic unsup_ff;
  ovt_test_mode_t mode_ff;
  ovt_phase_t phase_ff;
  logic [31:0] st_cnt_ff;
  logic [31:0] se0_cnt_ff;
  logic [31:0] ph_cnt_ff;
  logic [3:0] tmo;
  logic [31:0] ev;
  logic hc_reset;
  logic b_reset_seen;
  logic [31:0] status_w;

  assign ev = wr_to(OFS_EVENT) ? pwdata_i : 32'h0;
  assign hc_reset = ev[EV_HC_RESET];

  always_comb begin
    addr_ok = 1'b1;
    rd_mux = 32'h0;
    unique case (paddr_i)
      OFS_CTRL: rd_mux = {26'h0, ctrl_ff};
      OFS_STATE: rd_mux = {29'h0, state_ff};
      OFS_EVENT: rd_mux = 32'h0;
      OFS_STATUS: rd_mux = status_w;
      OFS_FLAGS: rd_mux = {30'h0, flags_ff};
      OFS_TEST_ID: rd_mux = test_id_ff;
      OFS_TEST_PORT: rd_mux = {28'h0, port_ff};
      OFS_TEST_STAT: rd_mux = {25'h0, unsup_ff, phase_ff, mode_ff};
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !addr_ok;
      if (setup) begin
        prdata_ff <= (pwrite_i || !addr_ok) ? 32'h0 : rd_mux;
      end
    end
  end

  // Software control registers
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_ff <= CTRL_RST;
      state_ff <= ST_OTHER;
      port_ff <= PORT_RST;
    end else begin
      if (wr_to(OFS_CTRL)) begin
        ctrl_ff <= pwdata_i[CTRL_W-1:0];
      end
      if (wr_to(OFS_STATE)) begin
        state_ff <= (pwdata_i[2:0] > 3'h5) ? ST_OTHER : ovt_otg_state_t'(pwdata_i[2:0]);
      end
      if (wr_to(OFS_TEST_PORT)) begin
        port_ff <= pwdata_i[PORT_W-1:0];
      end
    end
  end

  // One shared timer; timed states never overlap
  function automatic logic [31:0] limit_of(input ovt_otg_state_t st);
    unique case (st)
      ST_A_WAIT_VRISE: limit_of = VRISE_CYC;
      ST_A_WAIT_BCON: limit_of = BCON_CYC;
      ST_A_SUSPEND: limit_of = AIDL_CYC;
      ST_B_WAIT_ACON: limit_of = ASE0_CYC;
      default: limit_of = 32'hffff_ffff;
    endcase
  endfunction

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_state_ff <= ST_OTHER;
      st_cnt_ff <= 32'h0;
    end else begin
      prev_state_ff <= state_ff;
      if (state_ff != prev_state_ff) begin
        st_cnt_ff <= 32'h0;
      end else if (st_cnt_ff < limit_of(state_ff)) begin
        st_cnt_ff <= st_cnt_ff + 32'h1;
      end
    end
  end

  always_comb begin
    tmo = 4'h0;
    if (state_ff == prev_state_ff && st_cnt_ff >= limit_of(state_ff)) begin
      tmo[0] = (state_ff == ST_A_WAIT_VRISE);
      tmo[1] = (state_ff == ST_A_WAIT_BCON);
      tmo[2] = (state_ff == ST_A_SUSPEND);
      tmo[3] = (state_ff == ST_B_WAIT_ACON);
    end
  end

  // W1C error flags; a new event beats the clear
  logic overcur_set;
  logic ase0_set;

  assign overcur_set = tmo[0] && !sense_ff.a_vbus_vld && !tmout_o[0];
  assign ase0_set = tmo[3] && !sense_ff.se0 ? 1'b0 : tmo[3] && !tmout_o[3];
  assign b_reset_seen = ev[EV_B_BUS_RESET] || ase0_set;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags_ff <= 2'h0;
    end else begin
      if (wr_to(OFS_FLAGS)) begin
        flags_ff <= flags_ff & ~pwdata_i[1:0];
      end
      if (overcur_set) begin
        flags_ff[FL_VBUS_OVERCUR] <= 1'b1;
      end
      if (ase0_set) begin
        flags_ff[FL_ASE0_RESET] <= 1'b1;
      end
    end
  end

  // SE0 duration in B idle
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      se0_cnt_ff <= 32'h0;
      se0_srp_ff <= 1'b0;
    end else begin
      if (state_ff != ST_B_IDLE || !sense_ff.se0) begin
        se0_cnt_ff <= 32'h0;
        se0_srp_ff <= 1'b0;
      end else begin
        if (se0_cnt_ff <= SE0_SRP_CYC) begin
          se0_cnt_ff <= se0_cnt_ff + 32'h1;
        end
        se0_srp_ff <= (se0_cnt_ff > SE0_SRP_CYC);
      end
    end
  end

  // HNP flags; a set beats a same-cycle clear
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      a_hnp_ff <= 1'b0;
    end else if (ev[EV_A_HNP_SENT]) begin
      a_hnp_ff <= 1'b1;
    end else if ((state_ff == ST_A_WAIT_BCON && prev_state_ff != ST_A_WAIT_BCON)
                 || ctrl_ff[CTRL_BUS_RST]) begin
      a_hnp_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      b_hnp_ff <= 1'b0;
    end else if (ev[EV_B_HNP_ACCEPT]) begin
      b_hnp_ff <= 1'b1;
    end else if (b_reset_seen || !sense_ff.b_sess_vld) begin
      b_hnp_ff <= 1'b0;
    end
  end

  // Test-mode dispatcher; only the controller reset ends a mode
  function automatic ovt_test_mode_t decode_mode(input logic [15:0] pid);
    if (pid == PID_SE0_NAK) decode_mode = TM_SE0_NAK;
    else if (pid == PID_J) decode_mode = TM_J;
    else if (pid == PID_K) decode_mode = TM_K;
    else if (pid == PID_PACKET) decode_mode = TM_PACKET;
    else if (pid == PID_SUSP_RES) decode_mode = TM_SUSP_RES;
    else if (pid == PID_STEP_DESC) decode_mode = TM_STEP_DESC;
    else if (pid == PID_STEP_DATA) decode_mode = TM_STEP_DATA;
    else decode_mode = TM_NONE;
  endfunction

  logic id_wr;
  logic step_setup_ff;
  logic step_in_ff;
  logic ph_done;

  assign id_wr = wr_to(OFS_TEST_ID);
  assign ph_done = (phase_ff == PH_RESUME) ? (ph_cnt_ff >= RESUME_CYC) : (ph_cnt_ff >= STEP_CYC);

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      test_id_ff <= 32'h0;
      unsup_ff <= 1'b0;
    end else begin
      if (id_wr) begin
        test_id_ff <= pwdata_i;
      end
      if (id_wr && pwdata_i[31:16] == TEST_VID && pwdata_i[15:0] == PID_TEST_DEV) begin
        unsup_ff <= 1'b1;
      end else if (hc_reset) begin
        unsup_ff <= 1'b0;
      end
    end
  end

  // Mode and sequence phase
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_ff <= TM_NONE;
      phase_ff <= PH_IDLE;
      ph_cnt_ff <= 32'h0;
      step_setup_ff <= 1'b0;
      step_in_ff <= 1'b0;
    end else begin
      step_setup_ff <= 1'b0;
      step_in_ff <= 1'b0;
      ph_cnt_ff <= ph_done ? ph_cnt_ff : ph_cnt_ff + 32'h1;
      if (hc_reset) begin
        mode_ff <= TM_NONE;
        phase_ff <= PH_IDLE;
      end else if (mode_ff == TM_NONE) begin
        if (id_wr && pwdata_i[31:16] == TEST_VID) begin
          mode_ff <= decode_mode(pwdata_i[15:0]);
          ph_cnt_ff <= 32'h0;
          unique case (decode_mode(pwdata_i[15:0]))
            TM_SUSP_RES, TM_STEP_DESC: phase_ff <= PH_SOF_A;
            TM_STEP_DATA: begin
              phase_ff <= PH_WAIT_ACK;
              step_setup_ff <= 1'b1;
            end
            TM_NONE: phase_ff <= PH_IDLE;
            default: phase_ff <= PH_DONE;
          endcase
        end
      end else begin
        unique case (phase_ff)
          PH_SOF_A: if (ph_done) begin
            ph_cnt_ff <= 32'h0;
            if (mode_ff == TM_STEP_DESC) begin
              phase_ff <= PH_DONE;
              step_setup_ff <= 1'b1;
            end else begin
              phase_ff <= PH_SUSP;
            end
          end
          PH_SUSP: if (ph_done) begin
            phase_ff <= PH_RESUME;
            ph_cnt_ff <= 32'h0;
          end
          PH_RESUME: if (ph_done) begin
            phase_ff <= PH_DONE;
          end
          PH_WAIT_ACK: if (ev[EV_FIXTURE_ACK]) begin
            phase_ff <= PH_SOF_B;
            ph_cnt_ff <= 32'h0;
          end
          PH_SOF_B: if (ph_done) begin
            phase_ff <= PH_DONE;
            step_in_ff <= 1'b1;
          end
          PH_IDLE, PH_DONE: phase_ff <= phase_ff;
          default: phase_ff <= PH_DONE;
        endcase
      end
    end
  end

  // Test-port drive
  ovt_port_ctl_t port_nxt;

  always_comb begin
    port_nxt = '0;
    unique case (mode_ff)
      TM_SE0_NAK: begin
        port_nxt.hs_rx = 1'b1;
        port_nxt.drive_se0 = 1'b1;
      end
      TM_J: port_nxt.drive_j = 1'b1;
      TM_K: port_nxt.drive_k = 1'b1;
      TM_PACKET: port_nxt.send_packet = 1'b1;
      TM_SUSP_RES: begin
        port_nxt.suspend = (phase_ff == PH_SUSP);
        port_nxt.resume_k = (phase_ff == PH_RESUME);
        port_nxt.sof_en = (phase_ff == PH_SOF_A) || (phase_ff == PH_DONE);
      end
      TM_STEP_DESC, TM_STEP_DATA: port_nxt.sof_en = 1'b1;
      default: port_nxt = '0;
    endcase
  end

  assign status_w = {16'h0, tmo, b_hnp_ff, a_hnp_ff, se0_srp_ff, ctrl_ff[CTRL_BUS_RST],
                     2'h0, sense_ff.se0, sense_ff.b_sess_end, sense_ff.b_sess_vld,
                     sense_ff.a_sess_vld, sense_ff.a_vbus_vld, sense_ff.id};

  // Registered outputs
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      id_o <= 1'b1;
      a_suspend_req_o <= 1'b0;
      chrg_vbus_o <= 1'b0;
      drv_vbus_o <= 1'b0;
      loc_conn_o <= 1'b0;
      loc_sof_o <= 1'b0;
      b_se0_srp_o <= 1'b0;
      a_set_b_hnp_en_o <= 1'b0;
      b_hnp_en_o <= 1'b0;
      tmout_o <= 4'h0;
      unsupported_o <= 1'b0;
      test_mode_o <= TM_NONE;
      test_port_o <= PORT_RST;
      port_ctl_o <= '0;
    end else begin
      id_o <= sense_ff.id;
      a_suspend_req_o <= ctrl_ff[CTRL_SUSP_REQ];
      chrg_vbus_o <= ctrl_ff[CTRL_CHRG_VBUS];
      drv_vbus_o <= ctrl_ff[CTRL_DRV_VBUS];
      loc_conn_o <= ctrl_ff[CTRL_LOC_CONN];
      loc_sof_o <= ctrl_ff[CTRL_LOC_SOF] || ctrl_ff[CTRL_BUS_RST] || port_nxt.sof_en;
      b_se0_srp_o <= se0_srp_ff;
      a_set_b_hnp_en_o <= a_hnp_ff;
      b_hnp_en_o <= b_hnp_ff;
      tmout_o <= tmo;
      unsupported_o <= unsup_ff;
      test_mode_o <= mode_ff;
      if (mode_ff == TM_NONE) begin
        test_port_o <= port_ff;
      end
      port_ctl_o <= port_nxt;
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign step_setup_o = step_setup_ff;
  assign step_in_o = step_in_ff;

endmodule

// ### bench/ovt_core_monitor.sv
// Checker for control copies, bus errors and test modes
`timescale 1ns/1ps
module ovt_core_monitor
  import ovt_pkg::*;
(
  input wire logic clock_i, // Clock
  input wire logic arst_n_i, // Reset
  input wire logic psel_i, // Bus
  input wire logic penable_i, // Bus
  input wire logic pwrite_i, // Bus
  input wire logic [7:0] paddr_i, // Bus
  input wire logic [31:0] pwdata_i, // Bus
  input wire logic pready_o, // Bus
  input wire logic pslverr_o, // Bus
  input wire logic a_suspend_req_o, // Out
  input wire logic chrg_vbus_o, // Out
  input wire logic drv_vbus_o, // Out
  input wire logic loc_conn_o, // Out
  input wire logic b_hnp_en_o, // Out
  input wire ovt_sense_t sense_i, // Pins
  input wire ovt_test_mode_t test_mode_o, // Mode
  input wire logic [PORT_W-1:0] test_port_o, // Port
  input wire ovt_port_ctl_t port_ctl_o, // Drive
  input wire logic step_setup_o // Pulse
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);
  logic acc;
  logic [3:0] ctl_ff;
  logic [2:0] hc_ff;
  assign acc = psel_i && penable_i && pready_o;
  // Last CTRL write, judged two edges later
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) ctl_ff <= 4'h0;
    else if (acc && pwrite_i && paddr_i == OFS_CTRL) ctl_ff <= pwdata_i[3:0];
  end
  // Grace window after a controller reset event
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) hc_ff <= 3'h0;
    else if (acc && pwrite_i && paddr_i == OFS_EVENT && pwdata_i[EV_HC_RESET]) hc_ff <= 3'h5;
    else if (hc_ff != 3'h0) hc_ff <= hc_ff - 3'h1;
  end
  a_bad_addr: assert property (acc && paddr_i > OFS_TEST_STAT |-> pslverr_o)
    else $error("unmapped access without error");
  a_ctrl_copy: assert property (
    acc && pwrite_i && paddr_i == OFS_CTRL |->
    ##2 {loc_conn_o, drv_vbus_o, chrg_vbus_o, a_suspend_req_o} == ctl_ff)
    else $error("control outputs do not follow CTRL");
  a_hnp_lost: assert property (!sense_i.b_sess_vld [*8] |-> !b_hnp_en_o)
    else $error("b_hnp_en held without session");
  a_mode_exit: assert property (
    $past(test_mode_o) != TM_NONE && test_mode_o != $past(test_mode_o) |->
    test_mode_o == TM_NONE && hc_ff != 3'h0)
    else $error("test mode left without controller reset");
  a_port_frozen: assert property (
    $past(test_mode_o) != TM_NONE && test_mode_o != TM_NONE |-> $stable(test_port_o))
    else $error("port under test changed during a mode");
  a_nak_drive: assert property (
    test_mode_o == TM_SE0_NAK [*2] |-> port_ctl_o.hs_rx && port_ctl_o.drive_se0)
    else $error("se0 nak drive missing");
  a_j_drive: assert property (
    test_mode_o == TM_J [*2] |-> port_ctl_o.drive_j && !port_ctl_o.drive_k)
    else $error("j drive missing");
  a_step_pulse: assert property (step_setup_o |=> !step_setup_o)
    else $error("descriptor request longer than one cycle");
endmodule

// ### bench/ovt_fixture_model.sv
// Cable partner and test fixture model
`timescale 1ns/1ps
module ovt_fixture_model
  import ovt_pkg::*;
(
  input wire logic clock_i, // Clock
  input wire logic arst_n_i, // Reset, active low
  input wire logic a_plug_i, // A plug inserted
  input wire logic vbus_i, // VBUS present
  input wire logic se0_i, // Bus held at SE0
  input wire logic setup_i, // GetDescriptor from host
  output ovt_sense_t sense_o, // Comparator and line pins
  output logic ack_o // Fixture ACK pulse
);
  logic [2:0] dly_ff;
  assign sense_o.id = !a_plug_i;
  assign sense_o.a_vbus_vld = vbus_i;
  assign sense_o.a_sess_vld = vbus_i;
  assign sense_o.b_sess_vld = vbus_i;
  assign sense_o.b_sess_end = !vbus_i;
  assign sense_o.se0 = se0_i;
  // Late answer, like a real turnaround
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) dly_ff <= 3'h0;
    else dly_ff <= {dly_ff[1:0], setup_i};
  end
  assign ack_o = dly_ff[2];
endmodule

// ### bench/test_ovt_core.sv
// Self-checking bench for the dual-role block
`timescale 1ns/1ps
module test_ovt_core
  import ovt_pkg::*;
;
  localparam int VR = 40, BC = 50, AI = 30, AS = 20, SR = 20, ST = 60, RS = 20;
  // Identity values are arbitrary
  localparam logic [15:0] VID = 16'h3c3c;
  localparam logic [15:0] PID [9] = '{16'h4100, 16'h4101, 16'h4102, 16'h4103, 16'h4104,
    16'h4105, 16'h4106, 16'h4107, 16'h4108};
  localparam logic [7:0] PCX [5] = '{8'h00, 8'hc0, 8'h20, 8'h10, 8'h08};
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic a_plug = 1'b0, vbus = 1'b0, se0 = 1'b0, ack;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, id, susp, chrg, drv, conn, sof, srp, ahnp, bhnp, unsup, sset, sin;
  logic [3:0] tmo, port;
  logic [9:0] wv;
  ovt_sense_t sense;
  ovt_test_mode_t mode;
  ovt_port_ctl_t pc;
  int errors = 0, checks = 0;
  assign wv = {ack, srp, sin, sset, pc.resume_k, pc.suspend, tmo};
  always #50 clock_i = !clock_i;
  ovt_core #(.VRISE_CYC(VR), .BCON_CYC(BC), .AIDL_CYC(AI), .ASE0_CYC(AS),
    .SE0_SRP_CYC(SR), .STEP_CYC(ST), .RESUME_CYC(RS), .TEST_VID(VID), .PID_TEST_DEV(PID[0]),
    .PID_SE0_NAK(PID[1]), .PID_J(PID[2]), .PID_K(PID[3]), .PID_PACKET(PID[4]),
    .PID_SUSP_RES(PID[6]), .PID_STEP_DESC(PID[7]), .PID_STEP_DATA(PID[8])) i_ovt_core (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .sense_i(sense), .id_o(id),
    .a_suspend_req_o(susp), .chrg_vbus_o(chrg), .drv_vbus_o(drv), .loc_conn_o(conn),
    .loc_sof_o(sof), .b_se0_srp_o(srp), .a_set_b_hnp_en_o(ahnp), .b_hnp_en_o(bhnp),
    .tmout_o(tmo), .unsupported_o(unsup), .test_mode_o(mode), .test_port_o(port),
    .port_ctl_o(pc), .step_setup_o(sset), .step_in_o(sin));
  ovt_fixture_model i_ovt_fixture_model (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .a_plug_i(a_plug), .vbus_i(vbus), .se0_i(se0), .setup_i(sset), .sense_o(sense),
    .ack_o(ack));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wt(input int b, input int lo, input int hi, input string nm);
    int n;
    n = 0;
    while (wv[b] !== 1'b1 && n <= hi) begin
      tk(1);
      n++;
    end
    chk(nm, 1, n >= lo && n <= hi);
  endtask
  task automatic tid(input int i);
    apb(1'b1, OFS_TEST_ID, {VID, PID[i]});
    tk(3);
  endtask
  task automatic t_bus;
    chk("id", 1, id);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], er});
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, OFS_CTRL, 32'h1 << i);
      tk(3);
      chk("ctrl out", i < 4 ? 5'h1 << i : 5'h10, {sof, conn, drv, chrg, susp});
    end
    apb(1'b1, OFS_CTRL, 32'h0);
  endtask
  task automatic t_sense;
    @(posedge clock_i);
    a_plug <= 1'b1;
    vbus <= 1'b1;
    tk(6);
    chk("id low", 0, id);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status on", 5'h0e, rd[4:0]);
    @(posedge clock_i);
    a_plug <= 1'b0;
    vbus <= 1'b0;
    tk(6);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status off", 5'h11, rd[4:0]);
  endtask
  task automatic t_hnp;
    @(posedge clock_i);
    vbus <= 1'b1;
    tk(6);
    apb(1'b1, OFS_EVENT, 32'h3);
    tk(3);
    chk("hnp set", 2'h3, {ahnp, bhnp});
    apb(1'b1, OFS_STATE, 32'h3);
    tk(3);
    chk("bcon entry", 2'h1, {ahnp, bhnp});
    apb(1'b1, OFS_STATE, 32'h0);
    apb(1'b1, OFS_EVENT, 32'h1 << EV_A_HNP_SENT);
    apb(1'b1, OFS_CTRL, 32'h1 << CTRL_BUS_RST);
    tk(3);
    chk("a reset", 0, ahnp);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_EVENT, 32'h1 << EV_B_BUS_RESET);
    tk(3);
    chk("b reset", 0, bhnp);
    apb(1'b1, OFS_EVENT, 32'h1 << EV_B_HNP_ACCEPT);
    @(posedge clock_i);
    vbus <= 1'b0;
    tk(10);
    chk("b lost", 0, bhnp);
  endtask
  task automatic t_timers;
    int lim [4] = '{VR, BC, AI, AS};
    @(posedge clock_i);
    se0 <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_STATE, i + 2);
      wt(i, lim[i] - 2, lim[i] + 8, "timeout");
    end
    apb(1'b0, OFS_FLAGS, 32'h0);
    chk("flags", 2'h3, rd[1:0]);
    apb(1'b1, OFS_FLAGS, 32'h3);
    apb(1'b1, OFS_STATE, 32'h1);
    tk(3);
    chk("exit", 0, tmo);
    wt(8, SR - 4, SR + 8, "se0 srp");
    @(posedge clock_i);
    se0 <= 1'b0;
    tk(6);
    chk("srp off", 0, srp);
    apb(1'b1, OFS_STATE, 32'h0);
  endtask
  task automatic t_modes;
    for (int i = 1; i < 5; i++) begin
      apb(1'b1, OFS_TEST_PORT, i + 1);
      tid(i);
      chk("mode", i, mode);
      chk("drive", PCX[i], pc);
      apb(1'b1, OFS_TEST_PORT, 32'h9);
      tid(2 - i / 2);
      chk("held", {i[3:0], 4'(i + 1)}, {1'b0, mode, port});
      hcr();
      tk(3);
      chk("ended", TM_NONE, mode);
    end
    tid(5);
    chk("reserved", TM_NONE, mode);
    tid(0);
    chk("unsupported", 1, unsup);
    hcr();
  endtask
  task automatic hcr;
    apb(1'b1, OFS_EVENT, 32'h1 << EV_HC_RESET);
  endtask
  task automatic t_steps;
    tid(6);
    chk("sof", 1, pc.sof_en);
    wt(4, ST - 4, ST + 8, "suspend");
    wt(5, ST - 4, ST + 8, "resume");
    tk(RS + 6);
    chk("sof again", 2'h2, {pc.sof_en, pc.suspend});
    hcr();
    tid(7);
    wt(6, ST - 6, ST + 8, "get desc");
    chk("sof kept", 1, pc.sof_en);
    hcr();
    tid(8);
    wt(9, 0, 8, "fixture ack");
    apb(1'b1, OFS_EVENT, 32'h1 << EV_FIXTURE_ACK);
    wt(7, ST - 4, ST + 8, "in");
    hcr();
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2_000_000;
    errors++;
    finish_test();
  end
  initial begin
    tk(4);
    @(posedge clock_i);
    arst_n_i <= 1'b1;
    tk(4);
    t_bus();
    t_sense();
    t_hnp();
    t_timers();
    t_modes();
    t_steps();
    finish_test();
  end
endmodule
bind ovt_core ovt_core_monitor i_ovt_core_monitor (.clock_i(clock_i), .arst_n_i(arst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .a_suspend_req_o(a_suspend_req_o), .chrg_vbus_o(chrg_vbus_o), .drv_vbus_o(drv_vbus_o),
  .loc_conn_o(loc_conn_o), .b_hnp_en_o(b_hnp_en_o), .sense_i(sense_i),
  .test_mode_o(test_mode_o), .test_port_o(test_port_o), .port_ctl_o(port_ctl_o),
  .step_setup_o(step_setup_o));
